/* File: src/tmr_pkg.sv */
// Constants, types and register map of the 16-bit timer core
package tmr_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses on the 8-bit register port)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_A = 8'h00;
   localparam logic [7:0] OFS_CTRL_B = 8'h01;
   localparam logic [7:0] OFS_CNT_L  = 8'h02;
   localparam logic [7:0] OFS_CNT_H  = 8'h03;
   localparam logic [7:0] OFS_CAP_L  = 8'h04;
   localparam logic [7:0] OFS_CAP_H  = 8'h05;
   localparam logic [7:0] OFS_CMPA_L = 8'h06;
   localparam logic [7:0] OFS_CMPA_H = 8'h07;
   localparam logic [7:0] OFS_CMPB_L = 8'h08;
   localparam logic [7:0] OFS_CMPB_H = 8'h09;
   localparam logic [7:0] OFS_FLAG   = 8'h0a;
   localparam logic [7:0] OFS_MASK   = 8'h0b;
   localparam logic [7:0] OFS_PWR    = 8'h0c;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int FLG_OVF     = 0;
   localparam int FLG_CMPA    = 1;
   localparam int FLG_CMPB    = 2;
   localparam int FLG_CAP     = 3;
   localparam int NUM_FLAGS   = 4;
   localparam int CTB_EDGE    = 6;
   localparam int CTB_FILTER  = 7;
   localparam int PWR_DOWN    = 0;

   // -----------------------------------------------------------------
   // Reset values and fixed count points
   // -----------------------------------------------------------------
   localparam logic [7:0]  RST_CTRL   = 8'h00;
   localparam logic        RST_PWR    = 1'b1;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [15:0] COUNT_FLOOR = 16'h0000;
   localparam logic [15:0] COUNT_LIMIT = 16'hffff;
   localparam logic [15:0] CEIL_8BIT  = 16'h00ff;
   localparam logic [15:0] CEIL_9BIT  = 16'h01ff;
   localparam logic [15:0] CEIL_10BIT = 16'h03ff;
   localparam int          FILTER_LEN = 4;
   localparam int          PRE_BITS   = 10;

   // Counting modes, in field order of control A bits 2:0
   typedef enum logic [2:0] {
      MODE_NORMAL,
      MODE_CTC_A,
      MODE_PWM8,
      MODE_PWM9,
      MODE_PWM10,
      MODE_PWM_A,
      MODE_PWM_CAP
   } tmr_mode_t;

   // One register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tmr_req_t;

endpackage

/* File: src/tmr_core.sv */
// 16-bit timer/counter with byte-wide register access through a shared high byte
// Behaviour
// - Timer runs only while its power-down bit is zero.
// - Clock select zero stops all counting.
// - Tick comes from prescaler or external pin, rising or falling edge.
// - Counter, compare and capture are 16-bit; control registers are plain bytes.
// - Active compare values checked against counter; match sets flag, drives pin.
// - Overflow, two matches and capture flag; each masked onto interrupt.
// - Capture pin edge, optionally filtered, copies counter into capture value.
// - Floor is 0x0000 and limit is 0xffff.
// - Ceiling is 0x00ff, 0x01ff, 0x03ff, compare A or capture by mode.
// - Compare A as PWM ceiling gives no channel A output, buffered ceiling.
// - One shared 8-bit high byte holding register for all 16-bit registers.
// - Low-byte write loads held high byte plus written low byte at once; capture only while it sets the ceiling.
// - Counter or capture low-byte read latches high byte; high-byte read returns it.
// - Compare high bytes read directly, holding register untouched.
// - Holding register kept across low-byte writes; one high write serves many.
// - Counter stays accessible when stopped; CPU write beats count or clear.
`timescale 1ns/1ps
`default_nettype none
module tmr_core
   import tmr_pkg::*;
#(
   parameter int PRE_W = PRE_BITS
) (
   input  wire logic     clk_sys,
   input  wire logic     rstn,
   input  wire tmr_req_t bus_req,
   output var  logic [7:0] rdata,
   input  wire logic     external_count_pin,
   input  wire logic     capture_input_pin,
   output var  logic     compare_output_pin_a,
   output var  logic     compare_output_pin_b,
   output var  logic     irq
);

   // -----------------------------------------------------------------
   // Storage
   // -----------------------------------------------------------------
   logic [7:0]           ctrl_a;
   logic [7:0]           ctrl_b;
   logic                 pwr_down;
   logic [7:0]           hold;
   logic [15:0]          cnt;
   logic [15:0]          next_cnt;
   logic [15:0]          cap;
   logic [15:0]          cmpa_buf;
   logic [15:0]          cmpb_buf;
   logic [15:0]          cmpa_act;
   logic [15:0]          cmpb_act;
   logic [NUM_FLAGS-1:0] flag;
   logic [NUM_FLAGS-1:0] next_flag;
   logic [NUM_FLAGS-1:0] mask;
   logic [PRE_W-1:0]     pre;
   logic                 ext_s1, ext_s2, ext_s3;
   logic                 cap_s1, cap_s2;
   logic [FILTER_LEN-1:0] filt;
   logic                 cap_lvl, cap_d;
   logic                 blk;

   // Decoded helpers
   tmr_mode_t            mode;
   logic [2:0]           csel;
   logic                 wr_hi, wr_cnt, run, sel_tick, tick;
   logic                 pwm, top_hit, ovf_evt, cmpa_evt, cmpb_evt, cap_evt;
   logic [15:0]          ceiling;

   assign mode   = tmr_mode_t'(ctrl_a[2:0]);
   assign csel   = ctrl_b[2:0];
   assign wr_cnt = bus_req.wr && bus_req.addr == OFS_CNT_L;
   assign wr_hi  = bus_req.wr && (bus_req.addr == OFS_CNT_H || bus_req.addr == OFS_CAP_H ||
                   bus_req.addr == OFS_CMPA_H || bus_req.addr == OFS_CMPB_H);
   assign run    = !pwr_down && csel != 3'h0;
   assign pwm    = mode == MODE_PWM8 || mode == MODE_PWM9 || mode == MODE_PWM10 ||
                   mode == MODE_PWM_A || mode == MODE_PWM_CAP;

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   // Mode, clock select and power-down, plain byte writes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ctrl_a   <= RST_CTRL;
         ctrl_b   <= RST_CTRL;
         pwr_down <= RST_PWR;
         mask     <= '0;
      end else if (bus_req.wr) begin
         if (bus_req.addr == OFS_CTRL_A) ctrl_a <= bus_req.wdata;
         if (bus_req.addr == OFS_CTRL_B) ctrl_b <= bus_req.wdata;
         if (bus_req.addr == OFS_PWR) pwr_down <= bus_req.wdata[PWR_DOWN];
         if (bus_req.addr == OFS_MASK) mask <= bus_req.wdata[NUM_FLAGS-1:0];
      end
   end

   // -----------------------------------------------------------------
   // Tick generation
   // -----------------------------------------------------------------
   // Free prescaler, held at zero while stopped
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pre <= '0;
      end else if (!run) begin
         pre <= '0;
      end else begin
         pre <= pre + 1'b1;
      end
   end

   // External count pin synchroniser and edge stage
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= external_count_pin;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // Source and edge chosen by clock select
   always_comb begin
      case (csel)
         3'h1:    sel_tick = 1'b1;
         3'h2:    sel_tick = &pre[2:0];
         3'h3:    sel_tick = &pre[5:0];
         3'h4:    sel_tick = &pre[7:0];
         3'h5:    sel_tick = &pre[9:0];
         3'h6:    sel_tick = !ext_s2 && ext_s3;
         3'h7:    sel_tick = ext_s2 && !ext_s3;
         default: sel_tick = 1'b0;
      endcase
   end
   assign tick = run && sel_tick;

   // -----------------------------------------------------------------
   // Ceiling and counter
   // -----------------------------------------------------------------
   // Ceiling by mode
   always_comb begin
      case (mode)
         MODE_PWM8:    ceiling = CEIL_8BIT;
         MODE_PWM9:    ceiling = CEIL_9BIT;
         MODE_PWM10:   ceiling = CEIL_10BIT;
         MODE_CTC_A:   ceiling = cmpa_act;
         MODE_PWM_A:   ceiling = cmpa_act;
         MODE_PWM_CAP: ceiling = cap;
         default:      ceiling = COUNT_LIMIT;
      endcase
   end
   assign top_hit = cnt == ceiling;

   // Next count, CPU write first
   always_comb begin
      next_cnt = cnt;
      if (wr_cnt) begin
         next_cnt = {hold, bus_req.wdata};
      end else if (tick) begin
         next_cnt = top_hit ? COUNT_FLOOR : cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt <= RST_WORD;
      end else begin
         cnt <= next_cnt;
      end
   end

   // Counter write blocks the match on the next tick
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         blk <= 1'b0;
      end else if (wr_cnt) begin
         blk <= 1'b1;
      end else if (tick) begin
         blk <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Holding register
   // -----------------------------------------------------------------
   // Loaded by any high write, and by low reads of counter or capture
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold <= 8'h00;
      end else if (wr_hi) begin
         hold <= bus_req.wdata;
      end else if (bus_req.rd && bus_req.addr == OFS_CNT_L) begin
         hold <= cnt[15:8];
      end else if (bus_req.rd && bus_req.addr == OFS_CAP_L) begin
         hold <= cap[15:8];
      end
   end

   // -----------------------------------------------------------------
   // Compare registers
   // -----------------------------------------------------------------
   // Software side buffers, loaded whole on the low write
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cmpa_buf <= RST_WORD;
         cmpb_buf <= RST_WORD;
      end else if (bus_req.wr) begin
         if (bus_req.addr == OFS_CMPA_L) cmpa_buf <= {hold, bus_req.wdata};
         if (bus_req.addr == OFS_CMPB_L) cmpb_buf <= {hold, bus_req.wdata};
      end
   end

   // Active values follow at once, or at the ceiling in PWM modes
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cmpa_act <= RST_WORD;
         cmpb_act <= RST_WORD;
      end else if (!pwm || (tick && top_hit)) begin
         cmpa_act <= cmpa_buf;
         cmpb_act <= cmpb_buf;
      end
   end

   assign cmpa_evt = tick && !blk && !wr_cnt && cnt == cmpa_act;
   assign cmpb_evt = tick && !blk && !wr_cnt && cnt == cmpb_act;
   assign ovf_evt  = tick && !wr_cnt &&
                     (mode == MODE_CTC_A ? cnt == COUNT_LIMIT : top_hit);

   // Output pins: PWM set at wrap, clear on match; else toggle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         compare_output_pin_a <= 1'b0;
         compare_output_pin_b <= 1'b0;
      end else if (pwm) begin
         if (mode == MODE_PWM_A) compare_output_pin_a <= 1'b0;
         else if (cmpa_evt) compare_output_pin_a <= 1'b0;
         else if (tick && top_hit) compare_output_pin_a <= 1'b1;
         if (cmpb_evt) compare_output_pin_b <= 1'b0;
         else if (tick && top_hit) compare_output_pin_b <= 1'b1;
      end else begin
         if (cmpa_evt) compare_output_pin_a <= !compare_output_pin_a;
         if (cmpb_evt) compare_output_pin_b <= !compare_output_pin_b;
      end
   end

   // -----------------------------------------------------------------
   // Input capture
   // -----------------------------------------------------------------
   // Capture pin synchroniser
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cap_s1 <= 1'b0;
         cap_s2 <= 1'b0;
      end else begin
         cap_s1 <= capture_input_pin;
         cap_s2 <= cap_s1;
      end
   end

   // Noise filter: level changes after four equal samples
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         filt    <= '0;
         cap_lvl <= 1'b0;
         cap_d   <= 1'b0;
      end else begin
         filt  <= {filt[FILTER_LEN-2:0], cap_s2};
         cap_d <= cap_lvl;
         if (!ctrl_b[CTB_FILTER]) cap_lvl <= cap_s2;
         else if (&filt) cap_lvl <= 1'b1;
         else if (~|filt) cap_lvl <= 1'b0;
      end
   end

   assign cap_evt = cap_lvl != cap_d && cap_lvl == ctrl_b[CTB_EDGE] &&
                    mode != MODE_PWM_CAP && !pwr_down;

   // Capture value: event copy, or CPU write when it sets the ceiling
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cap <= RST_WORD;
      end else if (cap_evt) begin
         cap <= cnt;
      end else if (bus_req.wr && bus_req.addr == OFS_CAP_L && mode == MODE_PWM_CAP) begin
         cap <= {hold, bus_req.wdata};
      end
   end

   // -----------------------------------------------------------------
   // Flags and interrupt
   // -----------------------------------------------------------------
   // Write one clears; a same-cycle event wins
   always_comb begin
      next_flag = flag;
      if (bus_req.wr && bus_req.addr == OFS_FLAG) begin
         next_flag = flag & ~bus_req.wdata[NUM_FLAGS-1:0];
      end
      next_flag[FLG_OVF]  = next_flag[FLG_OVF] | ovf_evt;
      next_flag[FLG_CMPA] = next_flag[FLG_CMPA] | cmpa_evt;
      next_flag[FLG_CMPB] = next_flag[FLG_CMPB] | cmpb_evt;
      next_flag[FLG_CAP]  = next_flag[FLG_CAP] | cap_evt;
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flag <= '0;
         irq  <= 1'b0;
      end else begin
         flag <= next_flag;
         irq  <= |(flag & mask);
      end
   end

   // -----------------------------------------------------------------
   // Read port
   // -----------------------------------------------------------------
   // Data for one cycle after the read strobe, zero otherwise
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else if (!bus_req.rd) begin
         rdata <= 8'h00;
      end else begin
         case (bus_req.addr)
            OFS_CTRL_A: rdata <= ctrl_a;
            OFS_CTRL_B: rdata <= ctrl_b;
            OFS_CNT_L:  rdata <= cnt[7:0];
            OFS_CNT_H:  rdata <= hold;
            OFS_CAP_L:  rdata <= cap[7:0];
            OFS_CAP_H:  rdata <= hold;
            OFS_CMPA_L: rdata <= cmpa_buf[7:0];
            OFS_CMPA_H: rdata <= cmpa_buf[15:8];
            OFS_CMPB_L: rdata <= cmpb_buf[7:0];
            OFS_CMPB_H: rdata <= cmpb_buf[15:8];
            OFS_FLAG:   rdata <= {4'h0, flag};
            OFS_MASK:   rdata <= {4'h0, mask};
            OFS_PWR:    rdata <= {7'h00, pwr_down};
            default:    rdata <= 8'h00;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   sequence seq_cmpa_high;
      bus_req.wr && bus_req.addr == OFS_CMPA_H ##1 !bus_req.wr && !bus_req.rd;
   endsequence

   sequence seq_two_lows;
      bus_req.wr && bus_req.addr == OFS_CMPA_L ##1 !bus_req.wr && !bus_req.rd
      ##1 bus_req.wr && bus_req.addr == OFS_CMPB_L;
   endsequence

   chk_power_holds_count: assert property (
      pwr_down && !wr_cnt |=> cnt == $past(cnt))
      else $error("counter moved while powered down");

   chk_stop_holds_count: assert property (
      csel == 3'h0 && !wr_cnt |=> cnt == $past(cnt))
      else $error("counter moved with no clock selected");

   chk_low_write_load: assert property (
      wr_cnt |=> cnt == {$past(hold), $past(bus_req.wdata)})
      else $error("low write did not load full counter");

   chk_low_read_latch: assert property (
      bus_req.rd && bus_req.addr == OFS_CNT_L && !wr_hi
      |=> hold == $past(cnt[15:8]) && rdata == $past(cnt[7:0]))
      else $error("low read did not latch high byte");

   chk_cmp_high_direct: assert property (
      bus_req.rd && bus_req.addr == OFS_CMPA_H && !bus_req.wr
      |=> rdata == $past(cmpa_buf[15:8]) && hold == $past(hold))
      else $error("compare high read used holding register");

   chk_high_write_only: assert property (
      bus_req.wr && bus_req.addr == OFS_CMPB_H
      |=> hold == $past(bus_req.wdata) && cmpb_buf == $past(cmpb_buf))
      else $error("high write changed target register");

   chk_shared_high_byte: assert property (
      seq_cmpa_high ##1 seq_two_lows
      |=> cmpa_buf[15:8] == cmpb_buf[15:8] && hold == cmpb_buf[15:8])
      else $error("held high byte not reused");

   chk_match_flag_set: assert property (
      cmpa_evt |=> flag[FLG_CMPA] ##1 (irq || !$past(mask[FLG_CMPA])))
      else $error("compare match flag not set");

   chk_capture_copy: assert property (
      cap_evt |=> cap == $past(cnt) && flag[FLG_CAP])
      else $error("capture did not copy counter");

   chk_irq_follows: assert property (
      |(flag & mask) |=> irq)
      else $error("interrupt missing for unmasked flag");

   chk_ceiling_wrap: assert property (
      tick && !wr_cnt && mode == MODE_PWM9 && cnt == CEIL_9BIT |=> cnt == COUNT_FLOOR)
      else $error("counter did not wrap at ceiling");

   chk_pwm_a_off: assert property (
      mode == MODE_PWM_A [*2] |-> !compare_output_pin_a)
      else $error("channel A drives output while it sets the ceiling");

endmodule
`default_nettype wire

/* File: bench/tmr_cpu_model.sv */
// CPU-side model that drives the byte register port of the timer
`timescale 1ns/1ps
`default_nettype none
module tmr_cpu_model
   import tmr_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic [7:0] rdata,
   output var  tmr_req_t   bus_req
);
   // ---------------------------------------------------------------
   // Byte cycles
   // ---------------------------------------------------------------
   // Port idle from time zero
   initial bus_req = '0;

   // One write strobe, then address and data turned round
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // One read strobe, data taken in the following cycle
   task automatic rd8(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~a};
      @(posedge clk_sys);
      bus_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: a};
      @(negedge clk_sys);
      d = rdata;
   endtask

   // ---------------------------------------------------------------
   // Word cycles, never interleaved with other word accesses
   // ---------------------------------------------------------------
   // High byte first, low byte commits the word
   task automatic wr16(input logic [7:0] a_lo, input logic [15:0] v);
      wr8(a_lo + 8'h01, v[15:8]);
      wr8(a_lo, v[7:0]);
   endtask

   // Low byte first, high byte from the holding byte for counter and capture
   task automatic rd16(input logic [7:0] a_lo, output logic [15:0] v);
      logic [7:0] lo;
      logic [7:0] hi;
      rd8(a_lo, lo);
      rd8(a_lo + 8'h01, hi);
      v = {hi, lo};
   endtask
endmodule
`default_nettype wire

/* File: bench/tmr_core_bench.sv */
// Self-checking bench for the 16-bit timer core
`timescale 1ns/1ps
`default_nettype none
module tmr_core_bench
   import tmr_pkg::*;
   ;
   localparam logic [15:0] YES = 16'h0001;
   logic       clk_sys;
   logic       rstn;
   tmr_req_t   bus_req;
   logic [7:0] rdata;
   logic       ext_pin;
   logic       cap_pin;
   logic       pin_a;
   logic       pin_b;
   logic       irq;
   int         mismatches;
   int         checks;

   tmr_core #(.PRE_W(PRE_BITS)) dut (
      .clk_sys              (clk_sys),
      .rstn                 (rstn),
      .bus_req              (bus_req),
      .rdata                (rdata),
      .external_count_pin   (ext_pin),
      .capture_input_pin    (cap_pin),
      .compare_output_pin_a (pin_a),
      .compare_output_pin_b (pin_b),
      .irq                  (irq)
   );
   tmr_cpu_model cpu (
      .clk_sys (clk_sys),
      .rdata   (rdata),
      .bus_req (bus_req)
   );

   // ---------------------------------------------------------------
   // Clock, checking and closing
   // ---------------------------------------------------------------
   // 10 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report;
      $display("mismatches %0d checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // Fixed ceiling of the PWM modes
   function automatic logic [15:0] ceil_of(input logic [2:0] m);
      case (m)
         3'h2: ceil_of = CEIL_8BIT;
         3'h3: ceil_of = CEIL_9BIT;
         default: ceil_of = CEIL_10BIT;
      endcase
   endfunction

   // Run with a clock select, then stop keeping edge and filter bits
   task automatic run(input logic [7:0] cs, input int n);
      cpu.wr8(OFS_CTRL_B, cs);
      repeat (n) @(posedge clk_sys);
      cpu.wr8(OFS_CTRL_B, cs & 8'hc0);
   endtask

   // Slow pulses on the external count pin
   task automatic pulses(input int n);
      repeat (n) begin
         repeat (6) @(posedge clk_sys);
         ext_pin <= 1'b1;
         repeat (6) @(posedge clk_sys);
         ext_pin <= 1'b0;
      end
      repeat (8) @(posedge clk_sys);
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      final_report();
   end

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   initial begin
      logic [15:0] v;
      logic [15:0] c;
      logic [15:0] w;
      logic [15:0] prev;
      logic [15:0] bad;
      logic [7:0]  b;
      rstn = 1'b0;
      ext_pin = 1'b0;
      cap_pin = 1'b0;
      mismatches = 0;
      checks = 0;
      v = 16'($urandom(32'h1348));
      repeat (10) @(posedge clk_sys);
      rstn <= 1'b1;
      cpu.rd8(OFS_PWR, b);
      chk("pwr_reset", 16'(b), YES);
      cpu.rd8(8'h0d, b);
      chk("unmapped", 16'(b), 16'h0000);
      cpu.rd16(OFS_CNT_L, prev);
      chk("cnt_reset", prev, 16'h0000);
      // Byte staging through the shared holding byte, timer off
      repeat (4) begin
         v = 16'($urandom);
         c = 16'($urandom);
         c[15:8] = ~v[15:8];
         cpu.wr16(OFS_CMPA_L, c);
         cpu.wr8(OFS_CNT_H, ~v[15:8]);
         cpu.rd16(OFS_CNT_L, w);
         chk("cnt_after_high", w, prev);
         cpu.wr8(OFS_CNT_H, v[15:8]);
         cpu.wr8(OFS_CMPB_L, c[7:0]);
         cpu.wr8(OFS_CNT_L, v[7:0]);
         cpu.rd8(OFS_CNT_L, b);
         chk("cnt_low", 16'(b), 16'(v[7:0]));
         cpu.rd8(OFS_CMPA_H, b);
         chk("cmpa_high", 16'(b), 16'(c[15:8]));
         cpu.rd8(OFS_CNT_H, b);
         chk("cnt_high", 16'(b), 16'(v[15:8]));
         cpu.rd16(OFS_CMPB_L, w);
         chk("cmpb_shared", w, {v[15:8], c[7:0]});
         prev = v;
      end
      // One high byte serves two compare registers
      cpu.wr16(OFS_CMPA_L, prev ^ 16'h5a5a);
      cpu.wr8(OFS_CMPB_L, 8'h3c);
      cpu.rd16(OFS_CMPB_L, w);
      chk("cmpb_reuse", w, {prev[15:8] ^ 8'h5a, 8'h3c});
      // Power-down and clock select gating, CPU write priority
      run(8'h01, 20);
      cpu.rd16(OFS_CNT_L, w);
      chk("pwr_down_hold", w, prev);
      cpu.wr8(OFS_PWR, 8'h00);
      repeat (20) @(posedge clk_sys);
      cpu.rd16(OFS_CNT_L, w);
      chk("no_clock_hold", w, prev);
      cpu.wr8(OFS_CTRL_B, 8'h01);
      cpu.wr16(OFS_CNT_L, 16'h4000);
      cpu.rd16(OFS_CNT_L, w);
      chk("write_wins", 16'(w >= 16'h4000 && w < 16'h4010), YES);
      // External pin, both edges
      for (int cs = 7; cs >= 6; cs--) begin
         cpu.wr8(OFS_CTRL_B, 8'h00);
         cpu.wr16(OFS_CNT_L, 16'h0000);
         cpu.wr8(OFS_CTRL_B, 8'(cs));
         pulses(5);
         cpu.wr8(OFS_CTRL_B, 8'h00);
         cpu.rd16(OFS_CNT_L, w);
         chk("ext_count", w, 16'h0005);
      end
      // Prescaler divide by eight
      cpu.wr16(OFS_CNT_L, 16'h0000);
      run(8'h02, 80);
      cpu.rd16(OFS_CNT_L, w);
      chk("pre_div8", 16'(w >= 16'h0009 && w <= 16'h000b), YES);
      // Overflow at the limit, masking and clearing
      cpu.wr8(OFS_FLAG, 8'h0f);
      cpu.wr8(OFS_MASK, 8'h01);
      cpu.wr16(OFS_CNT_L, 16'hfff0);
      run(8'h01, 40);
      cpu.rd16(OFS_CNT_L, w);
      chk("wrap_floor", 16'(w < 16'h0040), YES);
      cpu.rd8(OFS_FLAG, b);
      chk("ovf_flag", 16'(b[FLG_OVF]), YES);
      chk("irq_on", 16'(irq), YES);
      cpu.wr8(OFS_MASK, 8'h00);
      repeat (2) @(negedge clk_sys);
      chk("irq_masked", 16'(irq), 16'h0000);
      cpu.wr8(OFS_MASK, 8'h01);
      cpu.wr8(OFS_FLAG, 8'h01);
      repeat (2) @(negedge clk_sys);
      chk("irq_cleared", 16'(irq), 16'h0000);
      // Compare matches on both channels
      cpu.wr8(OFS_MASK, 8'h02);
      cpu.wr8(OFS_FLAG, 8'h0f);
      cpu.wr16(OFS_CMPA_L, 16'h0020);
      cpu.wr16(OFS_CMPB_L, 16'h0030);
      cpu.wr16(OFS_CNT_L, 16'h0000);
      c = 16'({pin_a, pin_b});
      run(8'h01, 80);
      cpu.rd8(OFS_FLAG, b);
      chk("cmp_flags", 16'(b[2:1]), 16'h0003);
      chk("irq_cmp", 16'(irq), YES);
      chk("pins_toggle", 16'({pin_a, pin_b}), c ^ 16'h0003);
      // Capture, plain and filtered
      for (int f = 0; f < 2; f++) begin
         cpu.wr8(OFS_FLAG, 8'h0f);
         cpu.wr16(OFS_CNT_L, 16'h0000);
         cpu.wr8(OFS_CTRL_B, {f[0], 7'h41});
         repeat (20) @(posedge clk_sys);
         cap_pin <= 1'b1;
         repeat (20) @(posedge clk_sys);
         cpu.wr8(OFS_CTRL_B, {f[0], 7'h40});
         cap_pin <= 1'b0;
         cpu.rd8(OFS_FLAG, b);
         chk("cap_flag", 16'(b[FLG_CAP]), YES);
         cpu.rd16(OFS_CAP_L, w);
         chk("cap_value", 16'(w > 16'h000f && w < 16'h0028), YES);
      end
      // Clear on compare A
      cpu.wr8(OFS_CTRL_A, 8'h01);
      cpu.wr16(OFS_CMPA_L, 16'h0010);
      cpu.wr16(OFS_CNT_L, 16'h0000);
      run(8'h01, 40);
      cpu.rd16(OFS_CNT_L, w);
      chk("ctc_ceiling", 16'(w <= 16'h0010), YES);
      // Fixed ceilings
      for (int m = 2; m <= 4; m++) begin
         cpu.wr8(OFS_CTRL_A, 8'(m));
         cpu.wr16(OFS_CNT_L, ceil_of(3'(m)) - 16'h0008);
         run(8'h01, 30);
         cpu.rd16(OFS_CNT_L, w);
         chk("fixed_ceiling", 16'(w < 16'h0028), YES);
      end
      // Compare A as ceiling, channel A stays low
      cpu.wr8(OFS_CTRL_A, 8'h05);
      cpu.wr16(OFS_CMPA_L, 16'h0018);
      cpu.wr16(OFS_CNT_L, 16'h0000);
      cpu.wr8(OFS_CTRL_B, 8'h01);
      bad = 16'h0000;
      repeat (80) begin
         @(negedge clk_sys);
         if (pin_a !== 1'b0) bad++;
      end
      cpu.wr8(OFS_CTRL_B, 8'h00);
      chk("pin_a_quiet", bad, 16'h0000);
      cpu.rd16(OFS_CNT_L, w);
      chk("cmpa_ceiling", 16'(w <= 16'h0020), YES);
      // Capture value as ceiling
      cpu.wr8(OFS_CTRL_A, 8'h06);
      cpu.wr16(OFS_CAP_L, 16'h0018);
      cpu.wr16(OFS_CNT_L, 16'h0000);
      run(8'h01, 60);
      cpu.rd16(OFS_CNT_L, w);
      chk("cap_ceiling", 16'(w <= 16'h0018), YES);
      cpu.rd16(OFS_CAP_L, w);
      chk("cap_written", w, 16'h0018);
      final_report();
   end
endmodule
`default_nettype wire
